// ==== hdl/drive_reset_diag_handshake.sv ====
// Purpose: Primary drive side of the reset and diagnostic handshake.
// Assumes: reset_in is the host reset, already synchronous to clk_in.
// Notes: Line inputs are active-high "asserted" levels of the low-true
// lines; output enables are low while this drive pulls a line down.
// Window limits are counted in clock cycles, so a bench may shorten them;
// the defaults give the full millisecond and second windows at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "drive_reset_params.svh"
module drive_reset_diag_handshake
    import drive_reset_pkg::*;
#(
    parameter longint unsigned PRESENCE_OPEN = `PRESENCE_OPEN_CYCLES,
    parameter longint unsigned PRESENCE_CLOSE = `PRESENCE_CLOSE_CYCLES,
    parameter longint unsigned DIAG_OPEN = `DIAG_OPEN_CYCLES,
    parameter longint unsigned DIAG_CLOSE = `DIAG_CLOSE_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Shared open-drain lines, asserted level sampled
    input wire logic presence_activity_line_in,
    input wire logic diag_passed_line_in,
    // Shared open-drain line drivers
    output logic presence_activity_line_out,
    output logic presence_activity_line_oe_n_out,
    output logic diag_passed_line_out,
    output logic diag_passed_line_oe_n_out,
    // Status
    output logic status_busy_flag_out,
    output logic secondary_present_out,
    output logic secondary_diag_passed_out,
    output logic secondary_failed_out,
    output logic sequence_done_out
);
    // Synchronised line levels.
    logic presence_s;
    logic diag_s;
    // Sequence state and cycles elapsed since reset release.
    seq_state_t state_q;
    seq_state_t state_d;
    logic [35:0] elapsed_q;
    logic [35:0] elapsed_d;
    // Busy and the sticky status flags.
    logic busy_q;
    logic busy_d;
    logic present_q;
    logic present_d;
    logic passed_q;
    logic passed_d;
    logic failed_q;
    logic failed_d;
    logic done_q;
    logic done_d;
    // Registered line drivers.
    logic pres_drv_q;
    logic pres_drv_d;
    logic pres_oe_n_q;
    logic pres_oe_n_d;
    logic diag_drv_q;
    logic diag_drv_d;
    logic diag_oe_n_q;
    logic diag_oe_n_d;

    // True while the elapsed count lies inside [lo, hi].
    function automatic logic in_window(input logic [35:0] t,
                                       input longint unsigned lo,
                                       input longint unsigned hi);
        in_window = (64'(t) >= lo) && (64'(t) <= hi);
    endfunction : in_window

    // True once the elapsed count has reached the limit lim.
    function automatic logic reached(input logic [35:0] t,
                                     input longint unsigned lim);
        reached = 64'(t) >= lim;
    endfunction : reached

    // Both shared lines are driven from another drive's clock domain, so
    // each passes two flip-flops before the sequence looks at it.
    pin_sync u_presence_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(presence_activity_line_in),
        .sync_out(presence_s)
    );

    pin_sync u_diag_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(diag_passed_line_in),
        .sync_out(diag_s)
    );

    // Timer group. The count starts at the first edge after reset release
    // and freezes once the sequence is over, so it can never wrap.
    always_comb begin
        elapsed_d = elapsed_q;
        if (state_q != ST_DONE) begin
            elapsed_d = elapsed_q + 36'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            elapsed_q <= 36'h0;
        end else begin
            elapsed_q <= elapsed_d;
        end
    end

    // Sequence group. After reset release the primary raises busy at once,
    // then waits for the secondary to announce itself on the presence line
    // inside the presence window. A presence seen too early is not refused
    // outright: the level is simply not acted on until the window opens.
    // Once the secondary is known, the diag line is watched in the same way
    // inside the diag window; a level seen before that window opens is the
    // leftover of the secondary's reset state and is ignored. Every exit
    // drops busy and raises done; all status flags stick until reset.
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        present_d = present_q;
        passed_d = passed_q;
        failed_d = failed_q;
        done_d = done_q;
        case (state_q)
            ST_IDLE: begin
                // Busy is set on the first edge after reset release.
                busy_d = 1'b1; // RULE1
                state_d = ST_WAIT_PRESENCE;
            end
            ST_WAIT_PRESENCE: begin
                // A level seen before the window opens just waits here.
                if (presence_s &&
                    in_window(elapsed_q, PRESENCE_OPEN, PRESENCE_CLOSE)) begin
                    present_d = 1'b1; // RULE5
                    state_d = ST_WAIT_DIAG; // RULE2
                end else if (reached(elapsed_q, PRESENCE_CLOSE)) begin
                    // No secondary: self diagnostics alone end the sequence.
                    busy_d = 1'b0; // RULE2
                    done_d = 1'b1;
                    state_d = ST_DONE;
                end
            end
            ST_WAIT_DIAG: begin
                // A pass level left over from the secondary's reset state
                // falls before the window opens and is not taken.
                if (diag_s &&
                    in_window(elapsed_q, DIAG_OPEN, DIAG_CLOSE)) begin // RULE4
                    passed_d = 1'b1; // RULE3
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_DONE;
                end else if (reached(elapsed_q, DIAG_CLOSE)) begin
                    // Window closed without the pass level.
                    failed_d = 1'b1; // RULE5
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                // Flags and busy hold until the host resets the drives again.
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequence registers.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            present_q <= 1'b0;
            passed_q <= 1'b0;
            failed_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            present_q <= present_d;
            passed_q <= passed_d;
            failed_q <= failed_d;
            done_q <= done_d;
        end
    end

    // Line driver group. This drive's own self-test is taken as passed, so
    // it never pulls either shared line: the enables stay high (released)
    // from reset onward and the data bits hold the pulled-down level.
    always_comb begin
        pres_drv_d = 1'b0;
        pres_oe_n_d = 1'b1; // RULE2
        diag_drv_d = 1'b0;
        diag_oe_n_d = 1'b1; // RULE1
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pres_drv_q <= 1'b0;
            pres_oe_n_q <= 1'b1;
            diag_drv_q <= 1'b0;
            diag_oe_n_q <= 1'b1;
        end else begin
            pres_drv_q <= pres_drv_d;
            pres_oe_n_q <= pres_oe_n_d;
            diag_drv_q <= diag_drv_d;
            diag_oe_n_q <= diag_oe_n_d;
        end
    end

    // Every port is a plain copy of its register.
    assign presence_activity_line_out = pres_drv_q;
    assign presence_activity_line_oe_n_out = pres_oe_n_q;
    assign diag_passed_line_out = diag_drv_q;
    assign diag_passed_line_oe_n_out = diag_oe_n_q;
    assign status_busy_flag_out = busy_q;
    assign secondary_present_out = present_q;
    assign secondary_diag_passed_out = passed_q;
    assign secondary_failed_out = failed_q;
    assign sequence_done_out = done_q;
endmodule : drive_reset_diag_handshake
`default_nettype wire

// ==== hdl/drive_reset_params.svh ====
// Purpose: Constants for the drive reset and diagnostic handshake.
// Assumes: 100 MHz clock, 10 ns period.
// Notes: Times are kept in their own units; cycle counts derive from them.
// Contract
// RULE1 - Host holds reset 25 us; primary sets busy, releases diag within 400 ns.
// RULE2 - Primary releases presence within 1 ms, samples it from 1 to 450 ms.
// RULE3 - With secondary present, primary samples diag line from 1 ms to 31 s.
// RULE4 - Secondary drops diag within 1 ms, then asserts it within 30 s.
// RULE5 - Secondary present only if seen in window; failed if diag absent at close.
`ifndef DRIVE_RESET_PARAMS_SVH
`define DRIVE_RESET_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define RESET_PULSE_US 25
`define BUSY_SET_MAX_NS 400
`define PRESENCE_RELEASE_MAX_MS 1
`define PRESENCE_SAMPLE_MIN_MS 1
`define PRESENCE_SAMPLE_MAX_MS 450
`define DIAG_SAMPLE_MIN_MS 1
`define DIAG_SAMPLE_MAX_S 31
`define SEC_DIAG_NEGATE_MAX_MS 1
`define SEC_DIAG_ASSERT_MAX_S 30

`define BUSY_SET_CYCLES (`BUSY_SET_MAX_NS / `CLK_PERIOD_NS)
`define PRESENCE_RELEASE_CYCLES \
    (`PRESENCE_RELEASE_MAX_MS * 1000000 / `CLK_PERIOD_NS)
`define PRESENCE_OPEN_CYCLES \
    (`PRESENCE_SAMPLE_MIN_MS * 1000000 / `CLK_PERIOD_NS)
`define PRESENCE_CLOSE_CYCLES \
    (`PRESENCE_SAMPLE_MAX_MS * 1000000 / `CLK_PERIOD_NS)
`define DIAG_OPEN_CYCLES (`DIAG_SAMPLE_MIN_MS * 1000000 / `CLK_PERIOD_NS)
`define DIAG_CLOSE_CYCLES \
    (64'd`DIAG_SAMPLE_MAX_S * 64'd1000000000 / 64'd`CLK_PERIOD_NS)

`endif

// ==== hdl/drive_reset_pkg.sv ====
// Purpose: Types for the drive reset and diagnostic handshake.
// Assumes: Nothing beyond the parameter header.
// Notes: Sequencer states only.
package drive_reset_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_PRESENCE = 3'b001,
        ST_WAIT_DIAG = 3'b010,
        ST_DONE = 3'b011
    } seq_state_t;
endpackage : drive_reset_pkg

// ==== hdl/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a pin input.
// Assumes: Pin level is asynchronous to clk_in.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Pin
    input wire logic pin_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : pin_sync
`default_nettype wire

// ==== test/drive_reset_diag_handshake_tb.sv ====
// Purpose: Random and corner runs of the reset handshake.
// Assumes: Short window counts set on the instance.
// Notes: Presence limit 45 and diag limit 190 keep clear of edges.
`timescale 1ns/1ps
`default_nettype none
module drive_reset_diag_handshake_tb;
    logic clk_in = 0, reset_in = 1, pres, diag;
    logic busy, present, passed, failed, done;
    logic pdrv, poe, ddrv, doe;
    logic [15:0] pres_at = 16'hffff, diag_at = 16'hffff;
    logic [31:0] seed = 32'h00014771;
    int failures = 0, checked = 0, cycles = 0;
    drive_reset_diag_handshake #(.PRESENCE_OPEN(10), .PRESENCE_CLOSE(50),
        .DIAG_OPEN(10), .DIAG_CLOSE(200)) drive_reset_diag_handshake_inst (
        .clk_in, .reset_in, .presence_activity_line_in(pres),
        .diag_passed_line_in(diag), .presence_activity_line_out(pdrv),
        .presence_activity_line_oe_n_out(poe), .diag_passed_line_out(ddrv),
        .diag_passed_line_oe_n_out(doe), .status_busy_flag_out(busy),
        .secondary_present_out(present), .secondary_diag_passed_out(passed),
        .secondary_failed_out(failed), .sequence_done_out(done));
    secondary_drive_model secondary_drive_model_inst (.clk_in, .reset_in,
        .pres_at_in(pres_at), .diag_at_in(diag_at), .presence_out(pres),
        .diag_out(diag));
    initial forever #5 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic exp_pres(input logic [15:0] p);
        return p <= 16'd45;
    endfunction : exp_pres
    task automatic check(input string what, input logic e, input logic s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, e, s);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic trial(input logic [15:0] p, input logic [15:0] d);
        logic eg;
        eg = exp_pres(p) && d <= 16'd190;
        @(posedge clk_in);
        reset_in <= 1'b1;
        pres_at <= p;
        diag_at <= d;
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check("busy", 1'b1, busy);
        check("diag oe_n", 1'b1, doe);
        check("presence oe_n", 1'b1, poe);
        for (int k = 0; k < 400 && done !== 1'b1; k++) begin
            @(posedge clk_in);
            #1;
        end
        check("done", 1'b1, done);
        check("present", exp_pres(p), present);
        check("passed", eg, passed);
        check("failed", exp_pres(p) && !eg, failed);
        check("busy end", 1'b0, busy);
        check("line data", 1'b0, pdrv | ddrv);
        check("lines released", 1'b1, poe & doe);
        $display("trial %h %h ended", p, d);
    endtask : trial
    always @(posedge clk_in) if (++cycles == 10000) begin
        failures++;
        tally_and_finish();
    end
    initial begin
        trial(16'h0, 16'h1);
        trial(16'h2d, 16'hbe);
        trial(16'h3c, 16'h5);
        trial(16'h5, 16'hc9);
        trial(16'hffff, 16'hffff);
        repeat (12) begin
            seed = xs(seed);
            trial(seed[4] ? 16'hffff : {8'h0, seed[15:8] % 8'd46},
                seed[5] ? 16'hffff : {8'h0, seed[23:16] % 8'd190} + 16'h1);
        end
        tally_and_finish();
    end
endmodule : drive_reset_diag_handshake_tb
`default_nettype wire

// ==== test/handshake_props.sv ====
// Purpose: Checker for the primary drive reset handshake.
// Assumes: Counts below match the instance.
// Notes: n_q counts cycles since reset.
`timescale 1ns/1ps
`default_nettype none
module handshake_props #(
    parameter longint unsigned PRESENCE_OPEN = 10,
    parameter longint unsigned PRESENCE_CLOSE = 50,
    parameter longint unsigned DIAG_OPEN = 10,
    parameter longint unsigned DIAG_CLOSE = 200
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic presence_activity_line_oe_n_out,
    input wire logic diag_passed_line_oe_n_out,
    input wire logic status_busy_flag_out,
    input wire logic secondary_present_out,
    input wire logic secondary_diag_passed_out,
    input wire logic secondary_failed_out,
    input wire logic sequence_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    longint unsigned n_q;
    always_ff @(posedge clk_in) n_q <= reset_in ? 0 : n_q + 1;
    busy_hold_a: assert property (n_q > 1 && !sequence_done_out |->
        status_busy_flag_out) else $error("busy low early");
    done_idle_a: assert property (sequence_done_out |->
        !status_busy_flag_out) else $error("busy after done");
    lines_free_a: assert property (n_q > 0 |->
        diag_passed_line_oe_n_out && presence_activity_line_oe_n_out)
        else $error("line driven");
    present_win_a: assert property ($rose(secondary_present_out) |->
        n_q >= PRESENCE_OPEN && n_q <= PRESENCE_CLOSE + 3)
        else $error("presence outside window");
    diag_win_a: assert property ($rose(secondary_diag_passed_out) |->
        secondary_present_out && n_q >= DIAG_OPEN &&
        n_q <= DIAG_CLOSE + 1) else $error("diag outside window");
    fail_close_a: assert property ($rose(secondary_failed_out) |->
        secondary_present_out && !secondary_diag_passed_out &&
        n_q > DIAG_CLOSE) else $error("bad failure flag");
    cover property ($rose(secondary_present_out));
    cover property ($rose(secondary_diag_passed_out));
    cover property ($rose(secondary_failed_out));
    cover property ($rose(sequence_done_out) && !secondary_present_out);
endmodule : handshake_props
bind drive_reset_diag_handshake handshake_props #(
    .PRESENCE_OPEN(PRESENCE_OPEN), .PRESENCE_CLOSE(PRESENCE_CLOSE),
    .DIAG_OPEN(DIAG_OPEN), .DIAG_CLOSE(DIAG_CLOSE)) handshake_props_inst (
    .clk_in, .reset_in, .presence_activity_line_oe_n_out,
    .diag_passed_line_oe_n_out, .status_busy_flag_out,
    .secondary_present_out, .secondary_diag_passed_out,
    .secondary_failed_out, .sequence_done_out);
`default_nettype wire

// ==== test/secondary_drive_model.sv ====
// Purpose: Second drive on the shared lines.
// Assumes: Lines are given as asserted levels; released reads 0.
// Notes: A time of 16'hffff means never.
`timescale 1ns/1ps
`default_nettype none
module secondary_drive_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [15:0] pres_at_in,
    input wire logic [15:0] diag_at_in,
    output logic presence_out,
    output logic diag_out
);
    logic [15:0] n_q;
    always_ff @(posedge clk_in) n_q <= reset_in ? 16'h0 : n_q + 16'h1;
    assign presence_out = !reset_in && n_q >= pres_at_in;
    // Diag is held through reset and dropped until self-test passes.
    assign diag_out = reset_in || n_q >= diag_at_in;
endmodule : secondary_drive_model
`default_nettype wire
